// *** rtl/drmp_bank.v ***
// Drive parameter bank: slippage monitor, pulse input scaling, boot values, fieldbus masks
//
// Summary of operation
// [RULE_01] Persistent over-limit speed deviation sets status bit 13
// [RULE_02] Slip timeout: 16-bit ms, RW, resets to 100
// [RULE_03] Configured fault reaction also logs error entry
// [RULE_04] Pulse count multiplied by signed multiplier, reset 0x80
// [RULE_05] Pulse count divided by signed divider, reset 1
// [RULE_06] Mode 0 pulse/direction, mode 1 cw/ccw pulses
// [RULE_07] Boot sensor position captured once, read-only
// [RULE_08] Readiness held off for programmable ms delay
// [RULE_09] Availability: low half interfaces, high half protocols
// [RULE_10] Interface bit positions USB through SPI fixed
// [RULE_11] Protocol bits 16 to 18 fixed
// [RULE_12] Availability word read-only, reads 0x8
// [RULE_13] Fieldbus control word writable, resets to 0x8
// [RULE_14] Control word uses availability bit layout
// [RULE_15] Only mask-flagged buses switch; enabled word reported
// [RULE_16] Multiply before divide, wide intermediate, truncate
// [RULE_17] Persistence counter restarts when deviation returns
`timescale 1ns/100ps
`include "drmp_defines.vh"

module drmp_bank #(
	parameter MS_CYCLES = `DRMP_MS_CYCLES,
	parameter [31:0] FB_DISABLE_MASK = `DRMP_RST_FB_MASK
) (
	// Clock, reset, enable
	input wire clk,
	input wire rst,
	input wire ce,
	// Object access port
	input wire [15:0] obj_index,
	input wire [7:0] obj_subindex,
	input wire obj_wr,
	input wire obj_rd,
	input wire [31:0] obj_wdata,
	output reg [31:0] obj_rdata,
	output reg obj_ack,
	output reg obj_abort,
	// Slippage monitor inputs
	input wire [31:0] actual_speed,
	input wire [31:0] commanded_speed,
	input wire [31:0] slip_limit,
	input wire velocity_profile_active,
	input wire [15:0] fault_reaction_select,
	// Slippage results
	output reg drive_status_slip,
	output reg error_history_log,
	// Pulse input pins
	input wire pulse_in_a,
	input wire pulse_in_b,
	output reg [31:0] pulse_count,
	output reg [31:0] scaled_pulse_count,
	output reg pulse_div_zero,
	// Boot sensor and readiness
	input wire [31:0] abs_sensor_position,
	output reg drive_ready,
	// Fieldbus state
	output reg [31:0] fieldbus_enabled
);

	reg [15:0] slippage_timeout;
	reg [31:0] pulse_count_multiplier;
	reg [31:0] pulse_count_divider;
	reg [31:0] boot_sensor_position;
	reg [31:0] pulse_input_mode_select;
	reg [31:0] startup_hold_delay;
	reg [31:0] fieldbus_enable_control;

	reg [31:0] ms_div;
	reg ms_tick;
	reg [16:0] slip_ms;
	reg boot_captured;
	reg [31:0] boot_ms;
	reg [2:0] sync_a;
	reg [2:0] sync_b;
	reg [31:0] next_rdata;
	reg next_abort;
	reg [31:0] deviation;
	reg slip_excess;

	wire a_rise;
	wire b_rise;
	wire scl_busy;
	wire scl_done;
	wire scl_div_zero;
	wire [31:0] scl_result;
	wire obj_req;
	wire [31:0] fb_avail;

	function [31:0] abs32;
		input [31:0] v;
		begin
			abs32 = v[31] ? (~v + 32'h00000001) : v;
		end
	endfunction

	assign obj_req = obj_wr | obj_rd;
	assign fb_avail = `DRMP_FB_AVAIL_VALUE; // [RULE_09] [RULE_10] [RULE_11] [RULE_12]

	// ==========================================================================
	// Millisecond time base
	always @(posedge clk) begin
		if (rst) begin
			ms_div <= 32'h00000000;
			ms_tick <= 1'b0;
		end else if (ce) begin
			if (ms_div == MS_CYCLES - 1) begin
				ms_div <= 32'h00000000;
				ms_tick <= 1'b1;
			end else begin
				ms_div <= ms_div + 32'h00000001;
				ms_tick <= 1'b0;
			end
		end
	end

	// ==========================================================================
	// Slippage monitor
	always @* begin
		deviation = abs32(actual_speed - commanded_speed);
		slip_excess = velocity_profile_active && (deviation > abs32(slip_limit)); // [RULE_01]
	end

	always @(posedge clk) begin
		if (rst) begin
			slip_ms <= 17'h00000;
			drive_status_slip <= 1'b0;
			error_history_log <= 1'b0;
		end else if (ce) begin
			error_history_log <= 1'b0;
			if (!slip_excess) begin
				slip_ms <= 17'h00000; // [RULE_17]
				drive_status_slip <= 1'b0;
			end else begin
				if (ms_tick && (slip_ms <= {1'b0, slippage_timeout}))
					slip_ms <= slip_ms + 17'h00001;
				// Longer than the timeout, not equal to it
				if ((slip_ms > {1'b0, slippage_timeout}) && !drive_status_slip) begin
					drive_status_slip <= 1'b1; // [RULE_01]
					if (fault_reaction_select != 16'h0000)
						error_history_log <= 1'b1; // [RULE_03]
				end
			end
		end
	end

	// ==========================================================================
	// Pulse input synchronisers and counter
	always @(posedge clk) begin
		if (rst) begin
			sync_a <= 3'h0;
			sync_b <= 3'h0;
		end else if (ce) begin
			sync_a <= {sync_a[1:0], pulse_in_a};
			sync_b <= {sync_b[1:0], pulse_in_b};
		end
	end

	assign a_rise = sync_a[1] & ~sync_a[2];
	assign b_rise = sync_b[1] & ~sync_b[2];

	always @(posedge clk) begin
		if (rst) begin
			pulse_count <= 32'h00000000;
		end else if (ce) begin
			if (pulse_input_mode_select == `DRMP_MODE_CW_CCW) begin
				// Separate clockwise and counter-clockwise pulse lines
				if (a_rise && !b_rise)
					pulse_count <= pulse_count + 32'h00000001; // [RULE_06]
				else if (b_rise && !a_rise)
					pulse_count <= pulse_count - 32'h00000001; // [RULE_06]
			end else if (pulse_input_mode_select == `DRMP_MODE_PULSE_DIR) begin
				// Pulse on line a, direction level on line b
				if (a_rise)
					pulse_count <= sync_b[1] ? pulse_count - 32'h00000001 :
						pulse_count + 32'h00000001; // [RULE_06]
			end
		end
	end

	// ==========================================================================
	// Scaling of the accumulated count, restarted whenever idle
	drmp_pulse_scaler u_scaler (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.start(~scl_busy),
		.count(pulse_count),
		.multiplier(pulse_count_multiplier),
		.divider(pulse_count_divider),
		.busy(scl_busy),
		.done(scl_done),
		.div_zero(scl_div_zero),
		.result(scl_result)
	);

	always @(posedge clk) begin
		if (rst) begin
			scaled_pulse_count <= 32'h00000000;
			pulse_div_zero <= 1'b0;
		end else if (ce && scl_done) begin
			scaled_pulse_count <= scl_result; // [RULE_04] [RULE_05]
			pulse_div_zero <= scl_div_zero;
		end
	end

	// ==========================================================================
	// Boot capture and startup hold-off
	always @(posedge clk) begin
		if (rst) begin
			boot_captured <= 1'b0;
			boot_sensor_position <= `DRMP_RST_BOOT_POS;
			boot_ms <= 32'h00000000;
			drive_ready <= 1'b0;
		end else if (ce) begin
			if (!boot_captured) begin
				boot_captured <= 1'b1;
				boot_sensor_position <= abs_sensor_position; // [RULE_07]
			end
			if (!drive_ready) begin
				if (boot_ms >= startup_hold_delay)
					drive_ready <= 1'b1; // [RULE_08]
				else if (ms_tick)
					boot_ms <= boot_ms + 32'h00000001;
			end
		end
	end

	// ==========================================================================
	// Active fieldbus set
	always @(posedge clk) begin
		if (rst) begin
			fieldbus_enabled <= `DRMP_RST_FB_CTRL;
		end else if (ce) begin
			fieldbus_enabled <= (fieldbus_enable_control & FB_DISABLE_MASK) |
				(`DRMP_RST_FB_CTRL & ~FB_DISABLE_MASK); // [RULE_14] [RULE_15]
		end
	end

	// ==========================================================================
	// Object read decode
	always @* begin
		next_rdata = 32'h00000000;
		next_abort = 1'b0;
		case (obj_index)
		`DRMP_IDX_SLIP_TIMEOUT: next_rdata = {16'h0000, slippage_timeout};
		`DRMP_IDX_PULSE_MULT: next_rdata = pulse_count_multiplier;
		`DRMP_IDX_PULSE_DIV: next_rdata = pulse_count_divider;
		`DRMP_IDX_BOOT_POS: begin
			next_rdata = boot_sensor_position;
			next_abort = obj_wr; // [RULE_07]
		end
		`DRMP_IDX_PULSE_MODE: next_rdata = pulse_input_mode_select;
		`DRMP_IDX_STARTUP_DELAY: next_rdata = startup_hold_delay;
		`DRMP_IDX_FB_AVAIL: begin
			next_rdata = fb_avail;
			next_abort = obj_wr; // [RULE_12]
		end
		`DRMP_IDX_FB_CTRL: next_rdata = fieldbus_enable_control;
		`DRMP_IDX_FB_STATUS: begin
			next_abort = obj_wr;
			case (obj_subindex)
			`DRMP_SUB_COUNT: next_rdata = `DRMP_FB_STATUS_ENTRIES;
			`DRMP_SUB_MASK: next_rdata = FB_DISABLE_MASK;
			`DRMP_SUB_ENABLED: next_rdata = fieldbus_enabled; // [RULE_15]
			default: next_abort = 1'b1;
			endcase
		end
		default: next_abort = 1'b1;
		endcase
	end

	// ==========================================================================
	// Object write and answer
	always @(posedge clk) begin
		if (rst) begin
			slippage_timeout <= `DRMP_RST_SLIP_TIMEOUT; // [RULE_02]
			pulse_count_multiplier <= `DRMP_RST_PULSE_MULT;
			pulse_count_divider <= `DRMP_RST_PULSE_DIV;
			pulse_input_mode_select <= `DRMP_RST_PULSE_MODE;
			startup_hold_delay <= `DRMP_RST_STARTUP_DELAY;
			fieldbus_enable_control <= `DRMP_RST_FB_CTRL; // [RULE_13]
			obj_rdata <= 32'h00000000;
			obj_ack <= 1'b0;
			obj_abort <= 1'b0;
		end else if (ce) begin
			obj_ack <= obj_req;
			obj_abort <= obj_req & next_abort;
			if (obj_rd && !next_abort)
				obj_rdata <= next_rdata;
			if (obj_wr && !next_abort) begin
				case (obj_index)
				`DRMP_IDX_SLIP_TIMEOUT: slippage_timeout <= obj_wdata[15:0]; // [RULE_02]
				`DRMP_IDX_PULSE_MULT: pulse_count_multiplier <= obj_wdata; // [RULE_04]
				`DRMP_IDX_PULSE_DIV: pulse_count_divider <= obj_wdata; // [RULE_05]
				`DRMP_IDX_PULSE_MODE: pulse_input_mode_select <= obj_wdata; // [RULE_06]
				`DRMP_IDX_STARTUP_DELAY: startup_hold_delay <= obj_wdata; // [RULE_08]
				`DRMP_IDX_FB_CTRL: fieldbus_enable_control <= obj_wdata; // [RULE_13]
				default: ;
				endcase
			end
		end
	end

endmodule // drmp_bank

// *** rtl/drmp_defines.vh ***
// Object indices, field positions, reset values and timing of the drive parameter bank
`ifndef DRMP_DEFINES_VH
`define DRMP_DEFINES_VH

// ==========================================================================
// Object indices
`define DRMP_IDX_SLIP_TIMEOUT 16'h203F
`define DRMP_IDX_PULSE_MULT 16'h2057
`define DRMP_IDX_PULSE_DIV 16'h2058
`define DRMP_IDX_BOOT_POS 16'h205A
`define DRMP_IDX_PULSE_MODE 16'h205B
`define DRMP_IDX_STARTUP_DELAY 16'h2084
`define DRMP_IDX_FB_AVAIL 16'h2101
`define DRMP_IDX_FB_CTRL 16'h2102
`define DRMP_IDX_FB_STATUS 16'h2103

// Subindices of the fieldbus status array
`define DRMP_SUB_COUNT 8'h00
`define DRMP_SUB_MASK 8'h01
`define DRMP_SUB_ENABLED 8'h02
`define DRMP_FB_STATUS_ENTRIES 32'h00000002

// ==========================================================================
// Reset values
`define DRMP_RST_SLIP_TIMEOUT 16'h0064
`define DRMP_RST_PULSE_MULT 32'h00000080
`define DRMP_RST_PULSE_DIV 32'h00000001
`define DRMP_RST_BOOT_POS 32'h00000000
`define DRMP_RST_PULSE_MODE 32'h00000000
`define DRMP_RST_STARTUP_DELAY 32'h00000000
`define DRMP_FB_AVAIL_VALUE 32'h00000008
`define DRMP_RST_FB_CTRL 32'h00000008
`define DRMP_RST_FB_MASK 32'h00000000

// ==========================================================================
// Fieldbus bit positions
`define DRMP_FB_USB_BIT 0
`define DRMP_FB_RS485_BIT 1
`define DRMP_FB_RS232_BIT 2
`define DRMP_FB_CAN_BIT 3
`define DRMP_FB_ETHERNET_INTERFACE_BIT 4
`define DRMP_FB_INDUSTRIAL_ETHERNET_SLAVE_BIT 5
`define DRMP_FB_SPI_BIT 6
`define DRMP_FB_SERIAL_MODBUS_BIT 16
`define DRMP_FB_NETWORK_MODBUS_BIT 17
`define DRMP_FB_ETHERNET_INDUSTRIAL_PROTOCOL_BIT 18
`define DRMP_FB_PHYS_MASK 32'h0000FFFF
`define DRMP_FB_PROTO_MASK 32'hFFFF0000

// Status word bit raised on slippage
`define DRMP_STATUS_SLIP_BIT 13

// Pulse input modes
`define DRMP_MODE_PULSE_DIR 32'h00000000
`define DRMP_MODE_CW_CCW 32'h00000001

// ==========================================================================
// Timing
`define DRMP_MS_TIME_NS 1000000
`define DRMP_CLK_PERIOD_NS 5
`define DRMP_MS_CYCLES (`DRMP_MS_TIME_NS / `DRMP_CLK_PERIOD_NS)

`endif

// *** rtl/drmp_pulse_scaler.v ***
// Signed pulse count scaler: multiply first, then divide with truncation toward zero
`timescale 1ns/100ps
`include "drmp_defines.vh"

module drmp_pulse_scaler (
	// Clock and reset
	input wire clk,
	input wire rst,
	input wire ce,
	// Operation
	input wire start,
	input wire [31:0] count,
	input wire [31:0] multiplier,
	input wire [31:0] divider,
	output reg busy,
	output reg done,
	output reg div_zero,
	output reg [31:0] result
);

	localparam ST_IDLE = 2'b00;
	localparam ST_DIV = 2'b01;
	localparam ST_FIN = 2'b10;

	reg [1:0] state;
	reg [63:0] quo;
	reg [32:0] rem;
	reg [31:0] dmag;
	reg [6:0] step;
	reg neg;
	wire [63:0] product;
	wire [32:0] trial;

	function [63:0] mag64;
		input [63:0] v;
		begin
			mag64 = v[63] ? (~v + 64'h0000000000000001) : v;
		end
	endfunction

	// Full 64-bit product, no overflow for 32-bit operands
	assign product = $signed(count) * $signed(multiplier); // [RULE_16]
	assign trial = {rem[31:0], quo[63]} - {1'b0, dmag};

	// ==========================================================================
	// Restoring divider on magnitudes
	always @(posedge clk) begin
		if (rst) begin
			state <= ST_IDLE;
			quo <= 64'h0000000000000000;
			rem <= 33'h000000000;
			dmag <= 32'h00000000;
			step <= 7'h00;
			neg <= 1'b0;
			busy <= 1'b0;
			done <= 1'b0;
			div_zero <= 1'b0;
			result <= 32'h00000000;
		end else if (ce) begin
			done <= 1'b0;
			case (state)
			ST_IDLE: begin
				if (start) begin
					if (divider == 32'h00000000) begin
						div_zero <= 1'b1;
						result <= 32'h00000000;
						done <= 1'b1;
					end else begin
						div_zero <= 1'b0;
						neg <= product[63] ^ divider[31];
						quo <= mag64(product); // [RULE_04]
						dmag <= divider[31] ? (~divider + 32'h00000001) : divider; // [RULE_05]
						rem <= 33'h000000000;
						step <= 7'h00;
						busy <= 1'b1;
						state <= ST_DIV;
					end
				end
			end
			ST_DIV: begin
				if (!trial[32]) begin
					rem <= trial;
					quo <= {quo[62:0], 1'b1};
				end else begin
					rem <= {rem[31:0], quo[63]};
					quo <= {quo[62:0], 1'b0};
				end
				step <= step + 7'h01;
				if (step == 7'h3F)
					state <= ST_FIN;
			end
			ST_FIN: begin
				// Truncation toward zero: sign applied to the magnitude quotient
				result <= neg ? (~quo[31:0] + 32'h00000001) : quo[31:0]; // [RULE_05] [RULE_16]
				done <= 1'b1;
				busy <= 1'b0;
				state <= ST_IDLE;
			end
			default: begin
				state <= ST_IDLE;
				busy <= 1'b0;
			end
			endcase
		end
	end

endmodule // drmp_pulse_scaler

// *** verif/drmp_bank_props.sv ***
// Port checks of the drive parameter bank
`timescale 1ns/100ps
module drmp_bank_props #(
	parameter [31:0] FB_DISABLE_MASK = 32'h00000000
) (
	// Clock and reset
	input wire clk,
	input wire rst,
	input wire ce,
	// Object port
	input wire [15:0] obj_index,
	input wire obj_wr,
	input wire obj_rd,
	input wire [31:0] obj_rdata,
	input wire obj_ack,
	input wire obj_abort,
	// Slippage
	input wire [31:0] actual_speed,
	input wire [31:0] commanded_speed,
	input wire [31:0] slip_limit,
	input wire velocity_profile_active,
	input wire [15:0] fault_reaction_select,
	input wire drive_status_slip,
	input wire error_history_log,
	// Scaling and fieldbus
	input wire [31:0] scaled_pulse_count,
	input wire pulse_div_zero,
	input wire [31:0] fieldbus_enabled
);
	// ==========
	// Deviation beyond the limit magnitude
	wire [32:0] dev = {actual_speed[31], actual_speed} - {commanded_speed[31], commanded_speed};
	wire [32:0] dev_mag = dev[32] ? -dev : dev;
	wire [32:0] lim_mag = slip_limit[31] ? -{1'b1, slip_limit} : {1'b0, slip_limit};
	wire excess = velocity_profile_active && (dev_mag > lim_mag);
	wire req = ce && (obj_wr || obj_rd);

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	sequence s_slip_set;
		$rose(drive_status_slip);
	endsequence
	sequence s_excess_gone;
		ce && !excess;
	endsequence

	AST_ACK_ONE: assert property (req |=> obj_ack)
		else $error("request without ack");
	AST_ACK_CAUSE: assert property (obj_ack && $past(ce) |-> $past(req))
		else $error("ack without request");
	AST_AVAIL_RO: assert property (ce && obj_wr && obj_index == 16'h2101 |=> obj_abort)
		else $error("availability write not refused");
	AST_AVAIL_READ: assert property (ce && obj_rd && obj_index == 16'h2101 |=> obj_rdata == 32'h00000008)
		else $error("availability read wrong");
	AST_RDATA_HOLD: assert property (!$past(rst) && !$past(ce && obj_rd) |-> $stable(obj_rdata))
		else $error("read data moved without read");
	AST_SLIP_SET: assert property (s_slip_set |-> $past(excess))
		else $error("slip status without excess");
	AST_SLIP_CLEAR: assert property (s_excess_gone |=> !drive_status_slip)
		else $error("slip status kept after excess ended");
	AST_SLIP_LOG: assert property (error_history_log |-> s_slip_set)
		else $error("error log pulse off the slip set");
	AST_SLIP_NOLOG: assert property ($rose(drive_status_slip) && $past(fault_reaction_select) == 16'h0000 |-> !error_history_log)
		else $error("error log pulse without fault reaction");
	AST_FB_FIXED: assert property ((fieldbus_enabled & ~FB_DISABLE_MASK) == (32'h00000008 & ~FB_DISABLE_MASK))
		else $error("non switchable bus changed");
	AST_DIV_ZERO: assert property (pulse_div_zero |-> scaled_pulse_count == 32'h00000000)
		else $error("zero divider result not zero");
endmodule // drmp_bank_props

// *** verif/drmp_host.sv ***
// Fieldbus host model issuing object reads and writes
`timescale 1ns/100ps
module drmp_host (
	// Clock
	input wire clk,
	// Object requests
	output reg [15:0] obj_index,
	output reg [7:0] obj_subindex,
	output reg obj_wr,
	output reg obj_rd,
	output reg [31:0] obj_wdata
);
	initial begin
		obj_index = 16'h0000;
		obj_subindex = 8'h00;
		obj_wr = 1'b0;
		obj_rd = 1'b0;
		obj_wdata = 32'h00000000;
	end

	// One request pulse; released lines scrambled
	task xfer(input logic wr, input logic [15:0] ix, input logic [7:0] sb, input logic [31:0] d);
		begin
			@(posedge clk);
			#1;
			obj_wr = wr;
			obj_rd = !wr;
			obj_index = ix;
			obj_subindex = sb;
			obj_wdata = d;
			@(posedge clk);
			#1;
			obj_wr = 1'b0;
			obj_rd = 1'b0;
			obj_index = ~ix;
			obj_subindex = ~sb;
			obj_wdata = ~d;
		end
	endtask
endmodule // drmp_host

// *** verif/drmp_bank_tb.sv ***
// Self-checking bench of the drive parameter bank
`timescale 1ns/100ps
module drmp_bank_tb;
	localparam [31:0] FB_MASK = 32'h00070048;
	localparam [95:0] RW = {16'h203F, 16'h2057, 16'h2058, 16'h205B, 16'h2084, 16'h2102};
	reg clk = 1'b0;
	reg rst = 1'b1;
	reg ce = 1'b1;
	reg ce_seen = 1'b0;
	reg vp = 1'b0;
	reg pa = 1'b0;
	reg pb = 1'b0;
	reg [15:0] frs = 16'h0000;
	reg [31:0] act = 32'h00000000;
	reg [31:0] cmd = 32'h00000000;
	reg [31:0] lim = 32'h00000000;
	reg [31:0] abs_pos = 32'h00000000;
	reg [31:0] s = 32'h7427E86F;
	wire [15:0] obj_index;
	wire [7:0] obj_subindex;
	wire obj_wr, obj_rd, obj_ack, obj_abort, slip, log_p, pdz, rdy;
	wire [31:0] obj_wdata, obj_rdata, pcnt, spc, fbe;
	reg [33:0] q[$];
	reg [33:0] e;
	integer err_total = 0;
	integer total_checks = 0;
	integer cyc = 0;
	integer logs = 0;
	integer i;

	always #2.5 clk = ~clk;

	drmp_host host (.clk(clk), .obj_index(obj_index), .obj_subindex(obj_subindex),
		.obj_wr(obj_wr), .obj_rd(obj_rd), .obj_wdata(obj_wdata));

	drmp_bank #(.MS_CYCLES(10), .FB_DISABLE_MASK(FB_MASK)) dut (.clk(clk), .rst(rst), .ce(ce),
		.obj_index(obj_index), .obj_subindex(obj_subindex), .obj_wr(obj_wr), .obj_rd(obj_rd),
		.obj_wdata(obj_wdata), .obj_rdata(obj_rdata), .obj_ack(obj_ack), .obj_abort(obj_abort),
		.actual_speed(act), .commanded_speed(cmd), .slip_limit(lim), .velocity_profile_active(vp),
		.fault_reaction_select(frs), .drive_status_slip(slip), .error_history_log(log_p),
		.pulse_in_a(pa), .pulse_in_b(pb), .pulse_count(pcnt), .scaled_pulse_count(spc),
		.pulse_div_zero(pdz), .abs_sensor_position(abs_pos), .drive_ready(rdy),
		.fieldbus_enabled(fbe));

	function [31:0] nxt(input [31:0] v);
		nxt = {v[30:0], 1'b0} ^ (v[31] ? 32'h04C11DB7 : 32'h00000000);
	endfunction

	task chk(input string what, input [31:0] seen, input [31:0] exp);
		begin
			total_checks = total_checks + 1;
			if (seen !== exp) begin
				err_total = err_total + 1;
				$display("unexpected %s expected %h seen %h", what, exp, seen);
			end
		end
	endtask

	task give_verdict;
		begin
			$display("checks %0d mismatches %0d", total_checks, err_total);
			if (err_total == 0 && total_checks > 0)
				$display("verification passed");
			else
				$display("verification failed");
			$finish;
		end
	endtask

	// Note the expected answer, then issue the request
	task acc(input wr, input [15:0] ix, input [7:0] sb, input [31:0] d, input ab, input [31:0] ex);
		begin
			q.push_back({!wr && !ab, ab, ex});
			host.xfer(wr, ix, sb, d);
		end
	endtask

	task wait_cyc(input integer n);
		begin
			repeat (n) @(posedge clk);
			#1;
		end
	endtask

	task pulses(input integer n, input on_a);
		integer k;
		begin
			for (k = 0; k < n; k = k + 1) begin
				if (on_a)
					pa = 1'b1;
				else
					pb = 1'b1;
				wait_cyc(4);
				pa = 1'b0;
				pb = 1'b0;
				wait_cyc(4);
			end
		end
	endtask

	// ==========
	// Answer monitor
	always @(negedge clk) begin
		// Ack frozen by a low enable is one answer, not several
		if (!rst && ce_seen && obj_ack === 1'b1) begin
			if (q.size() == 0)
				chk("spare ack", 1, 0);
			else begin
				e = q.pop_front();
				chk("abort", obj_abort, e[32]);
				if (e[33])
					chk("rdata", obj_rdata, e[31:0]);
			end
		end
		if (log_p === 1'b1)
			logs = logs + 1;
	end

	always @(posedge clk) begin
		cyc = cyc + 1;
		ce_seen <= ce;
		if (cyc == 5000) begin
			err_total = err_total + 1;
			give_verdict;
		end
	end

	// ==========
	// Main sequence
	initial begin
		abs_pos = nxt(s);
		wait_cyc(4);
		rst = 1'b0;
		wait_cyc(3);
		chk("ready", rdy, 1);
		acc(0, 16'h203F, 0, 0, 0, 32'h00000064);
		acc(0, 16'h2057, 0, 0, 0, 32'h00000080);
		acc(0, 16'h2058, 0, 0, 0, 32'h00000001);
		acc(0, 16'h205A, 0, 0, 0, abs_pos);
		acc(0, 16'h205B, 0, 0, 0, 32'h00000000);
		acc(0, 16'h2084, 0, 0, 0, 32'h00000000);
		acc(0, 16'h2101, 0, 0, 0, 32'h00000008);
		acc(0, 16'h2102, 0, 0, 0, 32'h00000008);
		acc(0, 16'h2103, 8'h00, 0, 0, 32'h00000002);
		acc(0, 16'h2103, 8'h01, 0, 0, FB_MASK);
		acc(0, 16'h2103, 8'h02, 0, 0, 32'h00000008);
		acc(1, 16'h205A, 0, s, 1, 0);
		acc(1, 16'h2101, 0, s, 1, 0);
		acc(1, 16'h2103, 8'h02, s, 1, 0);
		acc(0, 16'h2100, 0, 0, 1, 0);
		acc(0, 16'h2103, 8'h03, 0, 1, 0);
		acc(0, 16'h205A, 0, 0, 0, abs_pos);
		abs_pos = ~abs_pos;
		acc(0, 16'h205A, 0, 0, 0, ~abs_pos);
		acc(0, 16'h2101, 0, 0, 0, 32'h00000008);
		for (i = 0; i < 6; i = i + 1) begin
			s = nxt(s);
			acc(1, RW[95 - 16 * i -: 16], 0, s, 0, 0);
			acc(0, RW[95 - 16 * i -: 16], 0, 0, 0, (i == 0) ? {16'h0000, s[15:0]} : s);
		end
		wait_cyc(2);
		chk("enabled", fbe, (s & FB_MASK) | (32'h00000008 & ~FB_MASK));
		acc(0, 16'h2103, 8'h02, 0, 0, (s & FB_MASK) | (32'h00000008 & ~FB_MASK));
		ce = 1'b0;
		host.xfer(0, 16'h2101, 0, 0);
		wait_cyc(2);
		ce = 1'b1;
		// Slippage: broken bursts must not trip, a steady one must
		acc(1, 16'h203F, 0, 2, 0, 0);
		lim = -32'd50;
		cmd = 32'd1000;
		frs = 16'h0001;
		vp = 1'b1;
		for (i = 0; i < 4; i = i + 1) begin
			act = 32'd1051;
			wait_cyc(15);
			act = 32'd1000;
			wait_cyc(1);
		end
		chk("slip", slip, 0);
		act = 32'd1051;
		wait_cyc(15);
		chk("slip", slip, 0);
		i = 0;
		while (slip !== 1'b1 && i < 40) begin
			wait_cyc(1);
			i = i + 1;
		end
		chk("slip", slip, 1);
		wait_cyc(2);
		chk("log", logs, 1);
		act = 32'd1000;
		wait_cyc(2);
		chk("slip", slip, 0);
		// Without a fault reaction the status still sets but nothing is logged
		frs = 16'h0000;
		act = 32'd1051;
		wait_cyc(40);
		chk("slip", slip, 1);
		chk("log", logs, 1);
		act = 32'd1000;
		wait_cyc(2);
		vp = 1'b0;
		// Pulse scaling in both input modes
		acc(1, 16'h2057, 0, 32'hFFFFFFFB, 0, 0);
		acc(1, 16'h2058, 0, 2, 0, 0);
		acc(1, 16'h205B, 0, 0, 0, 0);
		pulses(3, 1);
		wait_cyc(150);
		chk("count", pcnt, 3);
		chk("scaled", spc, 32'hFFFFFFF9);
		acc(1, 16'h205B, 0, 1, 0, 0);
		pulses(5, 0);
		wait_cyc(150);
		chk("count", pcnt, 32'hFFFFFFFE);
		chk("scaled", spc, 5);
		acc(1, 16'h2058, 0, 0, 0, 0);
		wait_cyc(150);
		chk("div zero", pdz, 1);
		// Second reset mid-run
		rst = 1'b1;
		wait_cyc(2);
		rst = 1'b0;
		acc(0, 16'h2102, 0, 0, 0, 32'h00000008);
		acc(0, 16'h2057, 0, 0, 0, 32'h00000080);
		wait_cyc(3);
		give_verdict;
	end
endmodule // drmp_bank_tb

bind drmp_bank drmp_bank_props #(.FB_DISABLE_MASK(FB_DISABLE_MASK)) u_props (.clk, .rst, .ce,
	.obj_index, .obj_wr, .obj_rd, .obj_rdata, .obj_ack, .obj_abort, .actual_speed,
	.commanded_speed, .slip_limit, .velocity_profile_active, .fault_reaction_select, .drive_status_slip,
	.error_history_log, .scaled_pulse_count, .pulse_div_zero, .fieldbus_enabled);
